// *** design/irq_ctrl.sv ***
`timescale 1ns/1ps
`include "irq_ctrl_map.svh"
module irq_ctrl
(
	// Clock and reset
	input  wire logic                 MCLK_I,
	input  wire logic                 RST_I,
	// Raw request flags from the peripherals
	input  wire logic                 SUPPLY_MONITOR_REQUEST_I,
	input  wire logic                 WATCHDOG_REQUEST_I,
	input  wire logic                 EXT_INT0_REQUEST_I,
	input  wire logic                 CONVERTER_REQUEST_I,
	input  wire logic                 TIMER0_OVERFLOW_I,
	input  wire logic                 EXT_INT1_REQUEST_I,
	input  wire logic                 TIMER1_OVERFLOW_I,
	input  wire logic                 TWOWIRE_REQUEST_I,
	input  wire logic                 FOURWIRE_REQUEST_I,
	input  wire logic                 UART_RECEIVE_DONE_I,
	input  wire logic                 UART_TRANSMIT_DONE_I,
	input  wire logic                 TIMER2_OVERFLOW_I,
	input  wire logic                 TIMER2_EXTERNAL_FLAG_I,
	input  wire logic                 INTERVAL_TIMER_REQUEST_I,
	// Core handshake
	input  wire logic                 CORE_ACCEPT_I,
	input  wire logic                 CORE_RETURN_I,
	output logic                      CORE_PUSH_O,
	output logic                      CORE_LOAD_O,
	output logic [15:0]               CORE_VECTOR_O,
	// AXI4-Lite write
	input  wire logic [11:0]          AWADDR_I,
	input  wire logic                 AWVALID_I,
	output logic                      AWREADY_O,
	input  wire logic [31:0]          WDATA_I,
	input  wire logic [3:0]           WSTRB_I,
	input  wire logic                 WVALID_I,
	output logic                      WREADY_O,
	output logic [1:0]                BRESP_O,
	output logic                      BVALID_O,
	input  wire logic                 BREADY_I,
	// AXI4-Lite read
	input  wire logic [11:0]          ARADDR_I,
	input  wire logic                 ARVALID_I,
	output logic                      ARREADY_O,
	output logic [31:0]               RDATA_O,
	output logic [1:0]                RRESP_O,
	output logic                      RVALID_O,
	input  wire logic                 RREADY_I,
	// Interrupt to the system
	output logic                      IRQ_O
);
	import irq_ctrl_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	logic [7:0]     pri_enable;
	logic [7:0]     pri_priority;
	logic [7:0]     sec_enpri;
	logic [2:0]     irq_status;
	logic [2:0]     irq_mask;
	logic           svc_high;
	logic           svc_low;
	logic [15:0]    vector;
	src_t           granted;
	grant_state_t   state;
	src_vec_t       req_raw;
	src_vec_t       req_en;
	src_vec_t       req_prio;
	logic [13:0]    sync1;
	logic [13:0]    sync2;
	logic           aw_held;
	logic           w_held;
	logic [11:0]    aw_addr;
	logic [31:0]    w_data;
	logic [3:0]     w_strb;
	logic           wr_go;
	logic           take;
	logic           grant_pulse;
	logic           preempt_pulse;
	logic           return_pulse;
	arb_if          arb ();

	irq_arbiter u_arb
	(
		.a (arb.arb)
	);

	function automatic logic [15:0] vec_of(input src_t s);
		unique case (s)
			SRC_PSM  : return `VEC_PSM;
			SRC_WD   : return `VEC_WD;
			SRC_X0   : return `VEC_X0;
			SRC_CONV : return `VEC_CONV;
			SRC_T0   : return `VEC_T0;
			SRC_X1   : return `VEC_X1;
			SRC_T1   : return `VEC_T1;
			SRC_SI   : return `VEC_SI;
			SRC_UART : return `VEC_UART;
			SRC_T2   : return `VEC_T2;
			SRC_TI   : return `VEC_TI;
			default  : return 16'h0000;
		endcase
	endfunction : vec_of

	function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] nw, input logic st);
		return st ? nw : old;
	endfunction : merge

	////////////////////////////////////////////////////////////////////////////////
	// Pin inputs cross two flops before use
	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			sync1 <= 14'h0000;
			sync2 <= 14'h0000;
		end
		else
		begin
			sync1 <= {SUPPLY_MONITOR_REQUEST_I, WATCHDOG_REQUEST_I, EXT_INT0_REQUEST_I, CONVERTER_REQUEST_I,
				TIMER0_OVERFLOW_I, EXT_INT1_REQUEST_I, TIMER1_OVERFLOW_I, TWOWIRE_REQUEST_I, FOURWIRE_REQUEST_I,
				UART_RECEIVE_DONE_I, UART_TRANSMIT_DONE_I, TIMER2_OVERFLOW_I, TIMER2_EXTERNAL_FLAG_I,
				INTERVAL_TIMER_REQUEST_I};
			sync2 <= sync1;
		end
	end

	always_comb
	begin
		req_raw[SRC_PSM]  = sync2[13];
		req_raw[SRC_WD]   = sync2[12];
		req_raw[SRC_X0]   = sync2[11];
		req_raw[SRC_CONV] = sync2[10];
		req_raw[SRC_T0]   = sync2[9];
		req_raw[SRC_X1]   = sync2[8];
		req_raw[SRC_T1]   = sync2[7];
		req_raw[SRC_SI]   = sync2[6] | sync2[5];
		req_raw[SRC_UART] = sync2[4] | sync2[3];
		req_raw[SRC_T2]   = sync2[2] | sync2[1];
		req_raw[SRC_TI]   = sync2[0];
		// Watchdog has no enable bit of its own and is gated only by the global enable
		req_en[SRC_PSM]   = sec_enpri[`SEC_PSM_EN];
		req_en[SRC_WD]    = 1'b1;
		req_en[SRC_X0]    = pri_enable[`PRI_X0];
		req_en[SRC_CONV]  = pri_enable[`PRI_CONV];
		req_en[SRC_T0]    = pri_enable[`PRI_T0];
		req_en[SRC_X1]    = pri_enable[`PRI_X1];
		req_en[SRC_T1]    = pri_enable[`PRI_T1];
		req_en[SRC_SI]    = sec_enpri[`SEC_SI_EN];
		req_en[SRC_UART]  = pri_enable[`PRI_UART];
		req_en[SRC_T2]    = pri_enable[`PRI_T2];
		req_en[SRC_TI]    = sec_enpri[`SEC_TI_EN];
		req_prio[SRC_PSM]  = sec_enpri[`SEC_PSM_PRIO];
		req_prio[SRC_WD]   = 1'b1;
		req_prio[SRC_X0]   = pri_priority[`PRI_X0];
		req_prio[SRC_CONV] = pri_priority[`PRI_CONV];
		req_prio[SRC_T0]   = pri_priority[`PRI_T0];
		req_prio[SRC_X1]   = pri_priority[`PRI_X1];
		req_prio[SRC_T1]   = pri_priority[`PRI_T1];
		req_prio[SRC_SI]   = sec_enpri[`SEC_SI_PRIO];
		req_prio[SRC_UART] = pri_priority[`PRI_UART];
		req_prio[SRC_T2]   = pri_priority[`PRI_T2];
		req_prio[SRC_TI]   = sec_enpri[`SEC_TI_PRIO];
	end

	// High requests blocked only by a high routine; low by any routine
	always_comb
	begin
		src_vec_t live;
		live = req_raw & req_en & {11{pri_enable[`PRI_GLOBAL_EN]}};
		arb.high_req = (svc_high) ? 11'h000 : (live & req_prio);
		arb.low_req  = (svc_high | svc_low) ? 11'h000 : (live & ~req_prio);
	end

	assign take = (state == ST_IDLE) & arb.found;

	////////////////////////////////////////////////////////////////////////////////
	// Grant sequence: push then load
	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			state   <= ST_IDLE;
			granted <= SRC_PSM;
			vector  <= 16'h0000;
		end
		else
		begin
			unique case (state)
				ST_IDLE :
				begin
					if (take)
					begin
						granted <= arb.winner;
						vector  <= vec_of(arb.winner);
						state   <= ST_PUSH;
					end
				end
				ST_PUSH :
				begin
					if (CORE_ACCEPT_I)
						state <= ST_LOAD;
				end
				ST_LOAD :
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Core strobes, from flops
	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			CORE_PUSH_O   <= 1'b0;
			CORE_LOAD_O   <= 1'b0;
			CORE_VECTOR_O <= 16'h0000;
		end
		else
		begin
			CORE_PUSH_O   <= take | (state == ST_PUSH && !CORE_ACCEPT_I);
			CORE_LOAD_O   <= (state == ST_PUSH) && CORE_ACCEPT_I;
			CORE_VECTOR_O <= take ? vec_of(arb.winner) : vector;
		end
	end

	// Service level stack, two deep
	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			svc_high <= 1'b0;
			svc_low  <= 1'b0;
		end
		else if (take)
		begin
			// A return in the grant cycle pops the low level; otherwise it stays set until the return after the high routine's
			if (arb.found_high)
			begin
				svc_high <= 1'b1;
				svc_low  <= svc_low & ~CORE_RETURN_I;
			end
			else
				svc_low <= 1'b1;
		end
		else if (CORE_RETURN_I)
		begin
			if (svc_high)
				svc_high <= 1'b0;
			else
				svc_low <= 1'b0;
		end
	end

	assign grant_pulse   = take;
	assign preempt_pulse = take & svc_low & ~CORE_RETURN_I;
	assign return_pulse  = CORE_RETURN_I & (svc_high | svc_low);

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write side
	assign wr_go = aw_held & w_held & ~BVALID_O;

	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_addr   <= 12'h000;
			w_data    <= 32'h0000_0000;
			w_strb    <= 4'h0;
			AWREADY_O <= 1'b0;
			WREADY_O  <= 1'b0;
			BVALID_O  <= 1'b0;
			BRESP_O   <= 2'h0;
		end
		else
		begin
			AWREADY_O <= ~aw_held & ~(AWVALID_I & AWREADY_O);
			WREADY_O  <= ~w_held & ~(WVALID_I & WREADY_O);
			if (AWVALID_I && AWREADY_O)
			begin
				aw_held <= 1'b1;
				aw_addr <= AWADDR_I;
			end
			if (WVALID_I && WREADY_O)
			begin
				w_held <= 1'b1;
				w_data <= WDATA_I;
				w_strb <= WSTRB_I;
			end
			if (wr_go)
			begin
				aw_held  <= 1'b0;
				w_held   <= 1'b0;
				BVALID_O <= 1'b1;
				BRESP_O  <= ({aw_addr[11:2], 2'b00} <= `OFS_CORE_CTRL) ? 2'h0 : 2'h2;
			end
			else if (BVALID_O && BREADY_I)
				BVALID_O <= 1'b0;
		end
	end

	// Register writes; bit 7 and bit 3 of the secondary register stay stored as written
	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			pri_enable   <= `RST_PRI_ENABLE;
			pri_priority <= `RST_PRI_PRIORITY;
			sec_enpri    <= `RST_SEC_ENPRI;
			irq_mask     <= 3'h0;
		end
		else if (wr_go)
		begin
			unique case ({aw_addr[11:2], 2'b00})
				`OFS_PRI_ENABLE   : pri_enable <= merge(pri_enable, w_data[7:0], w_strb[0]);
				`OFS_PRI_PRIORITY : pri_priority <= merge(pri_priority, w_data[7:0], w_strb[0]);
				// Whole-byte write only, never per bit
				`OFS_SEC_ENPRI    : sec_enpri <= merge(sec_enpri, w_data[7:0], w_strb[0]);
				`OFS_IRQ_MASK     : irq_mask <= w_strb[0] ? w_data[2:0] : irq_mask;
				default           : ;
			endcase
		end
	end

	// Sticky status, set beats a write-one clear
	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
			irq_status <= 3'h0;
		else
		begin
			logic [2:0] clr;
			clr = (wr_go && {aw_addr[11:2], 2'b00} == `OFS_IRQ_STATUS && w_strb[0]) ? w_data[2:0] : 3'h0;
			irq_status <= (irq_status & ~clr) | {return_pulse, preempt_pulse, grant_pulse};
		end
	end

	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= |(irq_status & irq_mask);
	end

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read side
	always_ff @(posedge MCLK_I or posedge RST_I)
	begin
		if (RST_I)
		begin
			ARREADY_O <= 1'b0;
			RVALID_O  <= 1'b0;
			RDATA_O   <= 32'h0000_0000;
			RRESP_O   <= 2'h0;
		end
		else
		begin
			ARREADY_O <= ~RVALID_O & ~(ARVALID_I & ARREADY_O);
			if (ARVALID_I && ARREADY_O)
			begin
				RVALID_O <= 1'b1;
				RRESP_O  <= 2'h0;
				unique case ({ARADDR_I[11:2], 2'b00})
					`OFS_PRI_ENABLE   : RDATA_O <= {24'h000000, pri_enable};
					`OFS_PRI_PRIORITY : RDATA_O <= {24'h000000, pri_priority};
					`OFS_SEC_ENPRI    : RDATA_O <= {24'h000000, sec_enpri};
					`OFS_IRQ_STATUS   : RDATA_O <= {29'h00000000, irq_status};
					`OFS_IRQ_MASK     : RDATA_O <= {29'h00000000, irq_mask};
					`OFS_GRANT_STATE  : RDATA_O <= {6'h00, vector, 1'b0, state, granted, svc_high, svc_low};
					`OFS_CORE_CTRL    : RDATA_O <= 32'h0000_0000;
					default           :
					begin
						RDATA_O <= 32'h0000_0000;
						RRESP_O <= 2'h2;
					end
				endcase
			end
			else if (RVALID_O && RREADY_I)
				RVALID_O <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	AST_NO_SAME_LEVEL: assert property (@(posedge MCLK_I) disable iff (RST_I)
		svc_high |-> !take) else $error("high routine preempted");
	AST_HIGH_FIRST: assert property (@(posedge MCLK_I) disable iff (RST_I)
		take && |arb.high_req |=> svc_high) else $error("low request beat high");
	AST_PUSH_BEFORE_LOAD: assert property (@(posedge MCLK_I) disable iff (RST_I)
		CORE_LOAD_O |-> $past(CORE_PUSH_O)) else $error("load without push");
	AST_VEC_PSM: assert property (@(posedge MCLK_I) disable iff (RST_I)
		take && arb.winner == SRC_PSM |=> CORE_VECTOR_O == 16'h0043) else $error("bad monitor vector");
	AST_VEC_X0: assert property (@(posedge MCLK_I) disable iff (RST_I)
		take && arb.winner == SRC_X0 |=> CORE_VECTOR_O == 16'h0003) else $error("bad ext0 vector");
	AST_WD_OVER_X0: assert property (@(posedge MCLK_I) disable iff (RST_I)
		take && arb.high_req[SRC_WD] |-> arb.winner != SRC_X0) else $error("ext0 beat watchdog");
	AST_GLOBAL_GATE: assert property (@(posedge MCLK_I) disable iff (RST_I)
		!pri_enable[`PRI_GLOBAL_EN] |-> !arb.found) else $error("request passed global gate");
	AST_ENABLE_GATE: assert property (@(posedge MCLK_I) disable iff (RST_I)
		!sec_enpri[`SEC_TI_EN] |-> !arb.high_req[SRC_TI] && !arb.low_req[SRC_TI]) else $error("disabled source");
	AST_PRIO_SEL: assert property (@(posedge MCLK_I) disable iff (RST_I)
		arb.high_req[SRC_PSM] |-> sec_enpri[`SEC_PSM_PRIO]) else $error("monitor level wrong");
	AST_IRQ_LEVEL: assert property (@(posedge MCLK_I) disable iff (RST_I)
		|(irq_status & irq_mask) |=> IRQ_O) else $error("irq not raised");
	COV_GRANT: cover property (@(posedge MCLK_I) disable iff (RST_I) take ##1 CORE_PUSH_O);
	COV_PREEMPT: cover property (@(posedge MCLK_I) disable iff (RST_I) preempt_pulse);
	COV_WRITE: cover property (@(posedge MCLK_I) disable iff (RST_I) BVALID_O && BREADY_I);
endmodule : irq_ctrl

// *** design/irq_ctrl_map.svh ***
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH
// Notes on behaviour
// - The secondary register holds priority selects at bit 6 (interval timer), bit 5 (supply monitor), bit 4 (serial).
// - The secondary register holds enables at bit 2 (interval timer), bit 1 (supply monitor), bit 0 (serial).
// - A source may request only while its enable is set, and sits at one of exactly two levels; the watchdog has no enable bit and is gated only by bit 7.
// - A pending enabled high-level request may preempt a running low-level service routine.
// - When requests of both levels arrive together, the high-level one is granted first.
// - A running routine is never preempted by a request of its own level.
// - Same-level order: supply monitor, watchdog, ext 0, converter, timer 0, ext 1, timer 1, serial, UART, timer 2, interval timer.
// - On a grant the core pushes the program counter before branching.
// - Vectors: ext 0 0003, timer 0 000B, ext 1 0013, timer 1 001B, UART 0023, timer 2 002B.
// - Vectors: converter 0033, serial 003B, supply monitor 0043, interval timer 0053, watchdog 005B.
// - Bit 7 of the primary enable register gates all sources.
// - The secondary register sits at special address A9, resets to A0, and is not bit addressable.

// Register byte offsets on the bus
`define OFS_PRI_ENABLE    12'h000
`define OFS_PRI_PRIORITY  12'h004
`define OFS_SEC_ENPRI     12'h008
`define OFS_IRQ_STATUS    12'h00C
`define OFS_IRQ_MASK      12'h010
`define OFS_GRANT_STATE   12'h014
`define OFS_CORE_CTRL     12'h018
// Special-function addresses, kept for software reference
`define SFR_PRI_ENABLE    8'hA8
`define SFR_SEC_ENPRI     8'hA9
`define SFR_PRI_PRIORITY  8'hB8
// Reset values
`define RST_PRI_ENABLE    8'h00
`define RST_PRI_PRIORITY  8'h00
`define RST_SEC_ENPRI     8'hA0
// Field positions, secondary register
`define SEC_TI_PRIO       6
`define SEC_PSM_PRIO      5
`define SEC_SI_PRIO       4
`define SEC_MBZ           3
`define SEC_TI_EN         2
`define SEC_PSM_EN        1
`define SEC_SI_EN         0
// Field positions, primary registers
`define PRI_GLOBAL_EN     7
`define PRI_CONV          6
`define PRI_T2            5
`define PRI_UART          4
`define PRI_T1            3
`define PRI_X1            2
`define PRI_T0            1
`define PRI_X0            0
// Vectors
`define VEC_X0            16'h0003
`define VEC_T0            16'h000B
`define VEC_X1            16'h0013
`define VEC_T1            16'h001B
`define VEC_UART          16'h0023
`define VEC_T2            16'h002B
`define VEC_CONV          16'h0033
`define VEC_SI            16'h003B
`define VEC_PSM           16'h0043
`define VEC_TI            16'h0053
`define VEC_WD            16'h005B
// Status bits
`define ST_GRANT          0
`define ST_PREEMPT        1
`define ST_RETURN         2
`endif

// *** design/irq_ctrl_pkg.sv ***
package irq_ctrl_pkg;
	// Sources in polling order, index 0 is polled first
	typedef enum logic [3:0] {
		SRC_PSM  = 4'h0,
		SRC_WD   = 4'h1,
		SRC_X0   = 4'h2,
		SRC_CONV = 4'h3,
		SRC_T0   = 4'h4,
		SRC_X1   = 4'h5,
		SRC_T1   = 4'h6,
		SRC_SI   = 4'h7,
		SRC_UART = 4'h8,
		SRC_T2   = 4'h9,
		SRC_TI   = 4'hA
	} src_t;
	typedef logic [10:0] src_vec_t;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PUSH = 3'b010,
		ST_LOAD = 3'b100
	} grant_state_t;
endpackage : irq_ctrl_pkg

// *** design/arb_if.sv ***
`timescale 1ns/1ps
interface arb_if;
	import irq_ctrl_pkg::*;
	src_vec_t    high_req;
	src_vec_t    low_req;
	logic        found;
	logic        found_high;
	src_t        winner;
	modport ctrl (output high_req, output low_req, input found, input found_high, input winner);
	modport arb  (input high_req, input low_req, output found, output found_high, output winner);
endinterface : arb_if

// *** design/irq_arbiter.sv ***
`timescale 1ns/1ps
module irq_arbiter
(
	arb_if.arb a
);
	import irq_ctrl_pkg::*;

	// Lowest index wins, giving the fixed polling order
	function automatic src_t first_set(input src_vec_t v);
		src_t r;
		r = SRC_PSM;
		for (int i = 10; i >= 0; i--)
		begin
			if (v[i])
				r = src_t'(i[3:0]);
		end
		return r;
	endfunction : first_set

	always_comb
	begin
		a.found      = |a.high_req | |a.low_req;
		a.found_high = |a.high_req;
		a.winner     = (|a.high_req) ? first_set(a.high_req) : first_set(a.low_req);
	end
endmodule : irq_arbiter

// *** bench/core_model.sv ***
`timescale 1ns/1ps
module core_model
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Controller side
	input  wire logic        push_i,
	input  wire logic        load_i,
	input  wire logic [15:0] vector_i,
	output logic             accept_o,
	output logic             ret_o,
	// Bench side
	input  wire logic [3:0]  delay_i,
	input  wire logic        ret_cmd_i,
	output logic [15:0]      got_vector_o,
	output int               loads_o
);
	logic [3:0] wait_cnt;
	////////////////////////////////////////////////////////////////
	// Stack push takes a bench-chosen number of cycles
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			accept_o <= 1'b0;
			wait_cnt <= 4'h0;
		end
		else if (!push_i)
		begin
			accept_o <= 1'b0;
			wait_cnt <= 4'h0;
		end
		else if (wait_cnt >= delay_i)
			accept_o <= 1'b1;
		else
			wait_cnt <= wait_cnt + 4'h1;
	end
	////////////////////////////////////////////////////////////////
	// Branch target taken from the load pulse
	always_ff @(posedge clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			got_vector_o <= 16'h0000;
			loads_o      <= 0;
			ret_o        <= 1'b0;
		end
		else
		begin
			ret_o <= ret_cmd_i;
			if (load_i)
			begin
				got_vector_o <= vector_i;
				loads_o      <= loads_o + 1;
			end
		end
	end
endmodule : core_model

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
	typedef struct packed {
		logic [7:0]  en;
		logic [7:0]  pri;
		logic [7:0]  sec;
		logic [13:0] req;
		logic [15:0] vec;
	} row_t;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic [13:0] req = 14'h0000;
	logic [11:0] awaddr = 12'h000;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [11:0] araddr = 12'h000;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [3:0]  dly = 4'h0;
	logic        ret_cmd = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq, push, load, accept, ret;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rd;
	logic [15:0] vector, got_vec;
	int          loads;
	int          err_count = 0;
	int          checks_done = 0;
	// Vector 0000 marks a row where nothing may be granted
	row_t rows [0:33] = '{
		'{8'hFF,8'h00,8'h07,14'h0001,16'h0043}, '{8'hFF,8'h00,8'h07,14'h0002,16'h005B},
		'{8'hFF,8'h00,8'h07,14'h0004,16'h0003}, '{8'hFF,8'h00,8'h07,14'h0008,16'h0033},
		'{8'hFF,8'h00,8'h07,14'h0010,16'h000B}, '{8'hFF,8'h00,8'h07,14'h0020,16'h0013},
		'{8'hFF,8'h00,8'h07,14'h0040,16'h001B}, '{8'hFF,8'h00,8'h07,14'h0080,16'h003B},
		'{8'hFF,8'h00,8'h07,14'h0100,16'h003B}, '{8'hFF,8'h00,8'h07,14'h0200,16'h0023},
		'{8'hFF,8'h00,8'h07,14'h0400,16'h0023}, '{8'hFF,8'h00,8'h07,14'h0800,16'h002B},
		'{8'hFF,8'h00,8'h07,14'h1000,16'h002B}, '{8'hFF,8'h00,8'h07,14'h2000,16'h0053},
		'{8'hFF,8'h00,8'h07,14'h0005,16'h0043}, '{8'hFF,8'h00,8'h07,14'h0006,16'h005B},
		'{8'hFF,8'h00,8'h07,14'h000C,16'h0003}, '{8'hFF,8'h00,8'h07,14'h0018,16'h0033},
		'{8'hFF,8'h00,8'h07,14'h0030,16'h000B}, '{8'hFF,8'h00,8'h07,14'h0060,16'h0013},
		'{8'hFF,8'h00,8'h07,14'h00C0,16'h001B}, '{8'hFF,8'h00,8'h07,14'h0300,16'h003B},
		'{8'hFF,8'h00,8'h07,14'h0A00,16'h0023}, '{8'hFF,8'h00,8'h07,14'h3000,16'h002B},
		'{8'hFF,8'h08,8'h07,14'h0044,16'h001B}, '{8'hFF,8'h00,8'h47,14'h2004,16'h0053},
		'{8'hFF,8'h00,8'h17,14'h0104,16'h003B}, '{8'hFF,8'h00,8'h27,14'h0003,16'h0043},
		'{8'hFF,8'h00,8'h05,14'h2001,16'h0053}, '{8'hFF,8'h00,8'h06,14'h2080,16'h0053},
		'{8'hFF,8'h00,8'h03,14'h2000,16'h0000}, '{8'hFF,8'h00,8'h05,14'h0001,16'h0000},
		'{8'h7F,8'h00,8'h07,14'h0004,16'h0000}, '{8'hFE,8'h00,8'h07,14'h0004,16'h0000}};
	logic [11:0] rst_addr [0:4] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010};
	logic [31:0] rst_val [0:4] = '{32'h0, 32'h0, 32'hA0, 32'h0, 32'h0};

	always #2 mclk = ~mclk;

	irq_ctrl uut (.MCLK_I(mclk), .RST_I(rst),
		.SUPPLY_MONITOR_REQUEST_I(req[0]), .WATCHDOG_REQUEST_I(req[1]), .EXT_INT0_REQUEST_I(req[2]),
		.CONVERTER_REQUEST_I(req[3]), .TIMER0_OVERFLOW_I(req[4]), .EXT_INT1_REQUEST_I(req[5]),
		.TIMER1_OVERFLOW_I(req[6]), .TWOWIRE_REQUEST_I(req[7]), .FOURWIRE_REQUEST_I(req[8]),
		.UART_RECEIVE_DONE_I(req[9]), .UART_TRANSMIT_DONE_I(req[10]), .TIMER2_OVERFLOW_I(req[11]),
		.TIMER2_EXTERNAL_FLAG_I(req[12]), .INTERVAL_TIMER_REQUEST_I(req[13]),
		.CORE_ACCEPT_I(accept), .CORE_RETURN_I(ret), .CORE_PUSH_O(push), .CORE_LOAD_O(load),
		.CORE_VECTOR_O(vector), .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready),
		.WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
		.BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
		.ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
		.RREADY_I(rready), .IRQ_O(irq));

	core_model core (.clk_i(mclk), .rst_i(rst), .push_i(push), .load_i(load), .vector_i(vector),
		.accept_o(accept), .ret_o(ret), .delay_i(dly), .ret_cmd_i(ret_cmd),
		.got_vector_o(got_vec), .loads_o(loads));
	////////////////////////////////////////////////////////////////
	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task results;
		$display("checks=%0d mismatches=%0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results

	task axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		while (!(aw_ok && w_ok))
		begin
			@(posedge mclk);
			if (!aw_ok && awready === 1'b1)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge mclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask : axi_wr

	task axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge mclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : axi_rd

	// Bounded wait; a grant counts only through the core's load pulse
	task expect_load(input logic [15:0] v);
		int n0;
		int k;
		n0 = loads;
		k = 0;
		while (loads == n0 && k < 30)
		begin
			@(posedge mclk);
			k++;
		end
		if (v == 16'h0000)
			check(32'(loads - n0), 32'h0);
		else
		begin
			// A missing load must fail even when the stale vector matches
			check(32'(loads - n0), 32'h1);
			check({16'h0, got_vec}, {16'h0, v});
		end
	endtask : expect_load

	// Requests drop before return so nothing re-grants behind us
	task finish_isr(input int n);
		req <= 14'h0000;
		repeat (4) @(posedge mclk);
		repeat (n)
		begin
			ret_cmd <= 1'b1;
			@(posedge mclk);
			ret_cmd <= 1'b0;
			repeat (4) @(posedge mclk);
		end
	endtask : finish_isr
	////////////////////////////////////////////////////////////////
	initial
	begin
		#100000;
		err_count++;
		results();
	end

	initial
	begin
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		for (int i = 0; i < 34; i++)
		begin
			dly <= 4'(i % 3);
			axi_wr(12'h000, {24'h0, rows[i].en}, resp);
			axi_wr(12'h004, {24'h0, rows[i].pri}, resp);
			axi_wr(12'h008, {24'h0, rows[i].sec}, resp);
			axi_rd(12'h008, rd, resp);
			check(rd, {24'h0, rows[i].sec});
			req <= rows[i].req;
			expect_load(rows[i].vec);
			finish_isr((rows[i].vec != 16'h0000) ? 1 : 0);
		end
		// Nesting: low routine, same-level block, high preempts
		axi_wr(12'h000, 32'hFF, resp);
		axi_wr(12'h004, 32'h00, resp);
		axi_wr(12'h008, 32'h27, resp);
		req <= 14'h0010;
		expect_load(16'h000B);
		req <= 14'h0030;
		expect_load(16'h0000);
		req <= 14'h0031;
		expect_load(16'h0043);
		finish_isr(2);
		// Status, mask and interrupt output
		axi_wr(12'h00C, 32'h7, resp);
		axi_wr(12'h010, 32'h0, resp);
		req <= 14'h0004;
		expect_load(16'h0003);
		check({31'h0, irq}, 32'h0);
		axi_rd(12'h00C, rd, resp);
		check(rd & 32'h1, 32'h1);
		axi_wr(12'h010, 32'h1, resp);
		repeat (2) @(posedge mclk);
		check({31'h0, irq}, 32'h1);
		axi_wr(12'h00C, 32'h1, resp);
		repeat (2) @(posedge mclk);
		check({31'h0, irq}, 32'h0);
		finish_isr(1);
		// Unmapped and reserved places
		axi_rd(12'h040, rd, resp);
		check({30'h0, resp}, 32'h2);
		check(rd, 32'h0);
		axi_wr(12'h040, 32'hFF, resp);
		check({30'h0, resp}, 32'h2);
		axi_rd(12'h018, rd, resp);
		check(rd, 32'h0);
		// Second reset in mid-run restores defaults
		axi_wr(12'h004, 32'hFF, resp);
		axi_wr(12'h008, 32'h55, resp);
		rst <= 1'b1;
		repeat (3) @(posedge mclk);
		check({31'h0, push}, 32'h0);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		for (int j = 0; j < 5; j++)
		begin
			axi_rd(rst_addr[j], rd, resp);
			check(rd, rst_val[j]);
		end
		results();
	end
endmodule : testbench
